// ---- nco_core.sv ----
// Waveform generator core: serial word receiver, frequency and phase
// registers, phase accumulator, sine or triangle shaping and square output.
// Assumes serial pins are asynchronous to clk and slow against 200 MHz.
`timescale 1ns/1ps
`default_nettype none
module nco_core
	import nco_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic             serial_clock,
	input  wire logic             serial_data_in,
	input  wire logic             frame_sync_n,
	output logic [DAC_W-1:0]      waveform_pin,
	output logic                  dac_active
);

	// ******************************
	// Pin synchronisers
	// ******************************
	logic sclk_meta, sclk_sync, sclk_prev;
	logic data_meta, data_sync;
	logic fs_meta, fs_sync;

	// Two flops per pin, a third for edge detection on the clean copy
	always_ff @(posedge clk) begin
		if (!rstn) begin
			{sclk_meta, sclk_sync, sclk_prev} <= 3'h7;
			{data_meta, data_sync}            <= 2'h0;
			{fs_meta, fs_sync}                <= 2'h3;
		end else begin
			{sclk_meta, sclk_sync, sclk_prev} <= {serial_clock, sclk_meta, sclk_sync};
			{data_meta, data_sync}            <= {serial_data_in, data_meta};
			{fs_meta, fs_sync}                <= {frame_sync_n, fs_meta};
		end
	end

	wire logic sclk_fall = sclk_prev & ~sclk_sync;

	// ******************************
	// Serial word receiver
	// ******************************
	rx_state_t           state, next_state;
	logic [3:0]          bit_count;
	logic [WORD_W-1:0]   shift;
	logic [WORD_W-1:0]   rx_word;
	logic                word_valid;

	// A bit is taken on each serial clock fall inside the frame, up to the sixteenth
	wire logic take_bit  = sclk_fall && !fs_sync && (state != RX_DONE);
	wire logic last_bit  = take_bit && (bit_count == LAST_BIT);

	// A frame that ends early is dropped; extra bits after 16 are ignored
	always_comb begin
		next_state = state;
		unique case (state)
			RX_IDLE:  if (!fs_sync) next_state = RX_SHIFT;
			RX_SHIFT: if (fs_sync) next_state = RX_IDLE;
			          else if (last_bit) next_state = RX_DONE;
			RX_DONE:  if (fs_sync) next_state = RX_IDLE;
			default:  next_state = RX_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			state      <= RX_IDLE;
			bit_count  <= 4'h0;
			shift      <= 16'h0000;
			rx_word    <= 16'h0000;
			word_valid <= 1'b0;
		end else begin
			state      <= next_state;
			bit_count  <= fs_sync ? 4'h0 : (take_bit ? bit_count + 4'h1 : bit_count);
			shift      <= take_bit ? {shift[WORD_W-2:0], data_sync} : shift;
			rx_word    <= last_bit ? {shift[WORD_W-2:0], data_sync} : rx_word;
			word_valid <= last_bit;
		end
	end

	// ******************************
	// Word decode
	// ******************************
	wire logic [1:0]        word_addr = rx_word[WORD_W-1:WORD_W-2];
	wire logic [HALF_W-1:0] payload   = rx_word[HALF_W-1:0];
	wire logic              wr_ctl    = word_valid && (word_addr == ADDR_CONTROL);

	// ******************************
	// Control register
	// ******************************
	logic [HALF_W-1:0] ctl;

	always_ff @(posedge clk) begin
		if (!rstn) ctl <= CTL_RESET_VAL;
		else if (wr_ctl) ctl <= payload;
	end

	wire logic full_word         = ctl[BIT_FULL_WORD];
	wire logic half_select       = ctl[BIT_HALF_SEL];
	wire logic frequency_select  = ctl[BIT_FREQ_SEL];
	wire logic phase_select      = ctl[BIT_PHASE_SEL];
	wire logic ctl_reset         = ctl[BIT_RESET];
	wire logic clock_halt        = ctl[BIT_CLOCK_HALT];
	wire logic dac_powerdown     = ctl[BIT_DAC_PD];
	wire logic bit_output_enable = ctl[BIT_BIT_OUT];
	wire logic msb_direct        = ctl[BIT_MSB_DIRECT];
	wire logic wave_mode         = ctl[BIT_MODE];

	// ******************************
	// Frequency and phase registers
	// ******************************
	logic [FREQ_W-1:0]  freq_word [2];
	logic [PHASE_W-1:0] phase_off [2];
	logic [FREQ_W-1:0]  next_freq [2];
	logic [1:0]         freq_hit;
	logic [1:0]         phase_hit;
	logic               pend_valid;
	logic               pend_target;
	logic [HALF_W-1:0]  pend_lsb;

	genvar t;
	generate
		for (t = 0; t < 2; t++) begin : g_regs
			localparam logic [1:0] TARGET = (t == 0) ? ADDR_FREQ_A : ADDR_FREQ_B;
			wire logic commit = freq_hit[t] && full_word && pend_valid && (pend_target == t);

			// Address decode of frequency and phase loads
			assign freq_hit[t]  = word_valid && (word_addr == TARGET);
			assign phase_hit[t] = word_valid && (word_addr == ADDR_PHASE)
			                      && (payload[BIT_PHASE_TGT] == t);

			// Second write of a pair commits both halves at once
			assign next_freq[t] = commit ? {payload, pend_lsb} :
			                      (freq_hit[t] && !full_word) ?
			                      (half_select ? {payload, freq_word[t][HALF_W-1:0]}
			                                   : {freq_word[t][FREQ_W-1:HALF_W], payload})
			                      : freq_word[t];

			// Register storage, not touched by the reset bit
			always_ff @(posedge clk) begin
				if (!rstn) begin
					freq_word[t] <= 28'h000_0000;
					phase_off[t] <= 12'h000;
				end else begin
					freq_word[t] <= next_freq[t];
					if (phase_hit[t]) phase_off[t] <= payload[PHASE_W-1:0];
				end
			end
		end
	endgenerate

	wire logic [FREQ_W-1:0]  frequency_word_a = freq_word[0];
	wire logic [FREQ_W-1:0]  frequency_word_b = freq_word[1];
	wire logic [PHASE_W-1:0] phase_offset_a   = phase_off[0];
	wire logic [PHASE_W-1:0] phase_offset_b   = phase_off[1];
	wire logic               any_freq_hit     = |freq_hit;
	wire logic               hit_target       = freq_hit[1];

	// First write of a pair is held until its partner arrives; a control word or a write to the other frequency register drops it
	always_ff @(posedge clk) begin
		if (!rstn) begin
			pend_valid  <= 1'b0;
			pend_target <= 1'b0;
			pend_lsb    <= 14'h0000;
		end else if (wr_ctl) begin
			pend_valid  <= 1'b0;
		end else if (any_freq_hit && full_word) begin
			pend_valid  <= !(pend_valid && (pend_target == hit_target));
			pend_target <= hit_target;
			pend_lsb    <= (pend_valid && (pend_target == hit_target)) ? pend_lsb : payload;
		end
	end

	// ******************************
	// Phase accumulator and offset
	// ******************************
	wire logic [FREQ_W-1:0]  active_freq  = frequency_select ? frequency_word_b
	                                                         : frequency_word_a;
	wire logic [PHASE_W-1:0] active_phase = phase_select ? phase_offset_b
	                                                     : phase_offset_a;
	// Internal clock runs unless the halt sleep bit or the reset bit is set
	wire logic run = !ctl_reset && !clock_halt;
	logic [FREQ_W-1:0]  acc;
	logic [PHASE_W-1:0] phase_sum;
	logic [DAC_W-1:0]   tri_wave;
	logic [3:0]         hold_count;
	logic [DAC_W-1:0]   dac_code;
	logic               msb_prev;
	logic               half_square;

	// Wraps modulo 2^28; halt freezes it, reset bit clears it
	always_ff @(posedge clk) begin
		if (!rstn || ctl_reset) acc <= 28'h000_0000;
		else if (run) acc <= acc + active_freq;
	end

	// Upper 12 accumulator bits plus offset: one step is 2pi/4096
	always_ff @(posedge clk) begin
		if (!rstn || ctl_reset) phase_sum <= 12'h000;
		else if (run) phase_sum <= acc[FREQ_W-1:ACC_LO] + active_phase;
	end

	// ******************************
	// Amplitude shaping
	// ******************************
	sine_lookup_if lookup_bus ();
	assign lookup_bus.phase = phase_sum;

	sine_lookup_rom u_sine_lookup (
		.clk  (clk),
		.port (lookup_bus.lookup)
	);

	// Triangle from the truncated phase, aligned with the lookup delay
	always_ff @(posedge clk) begin
		if (!rstn) tri_wave <= DAC_ZERO;
		else tri_wave <= phase_sum[PHASE_W-1] ? ~phase_sum[PHASE_W-2:1]
		                                      : phase_sum[PHASE_W-2:1];
	end

	wire logic [DAC_W-1:0] shaped = wave_mode ? tri_wave
	                                          : lookup_bus.amplitude;

	// Counts the settling cycles after the reset bit drops
	always_ff @(posedge clk) begin
		if (!rstn || ctl_reset) hold_count <= RESET_LATENCY;
		else if (!clock_halt && hold_count != 4'h0) hold_count <= hold_count - 4'h1;
	end

	// DAC data: midscale while settling, frozen while halted
	always_ff @(posedge clk) begin
		if (!rstn || hold_count != 4'h0) dac_code <= DAC_MIDSCALE;
		else if (!clock_halt) dac_code <= shaped;
	end

	// ******************************
	// Square output and pin
	// ******************************
	always_ff @(posedge clk) begin
		if (!rstn || ctl_reset) begin
			msb_prev    <= 1'b0;
			half_square <= 1'b0;
		end else begin
			msb_prev    <= dac_code[DAC_W-1];
			half_square <= half_square ^ (dac_code[DAC_W-1] & ~msb_prev);
		end
	end

	wire logic square = msb_direct ? dac_code[DAC_W-1] : half_square;
	wire logic [DAC_W-1:0] next_pin = bit_output_enable ? {DAC_W{square}} :
	                                  dac_powerdown ? DAC_ZERO : dac_code;

	// Pin and DAC power state are registered
	always_ff @(posedge clk) begin
		if (!rstn) begin
			waveform_pin <= DAC_MIDSCALE;
			dac_active   <= 1'b1;
		end else begin
			waveform_pin <= next_pin;
			dac_active   <= !dac_powerdown;
		end
	end

	// ******************************
	// Assertions
	// ******************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	chk_accum_step: assert property (run |=> acc == $past(acc + active_freq))
		else $error("accumulator did not add the selected word");
	chk_reset_clears: assert property (ctl_reset |=> acc == 28'h000_0000 ##1
		dac_code == DAC_MIDSCALE)
		else $error("reset bit did not clear accumulation");
	chk_halt_freeze: assert property (clock_halt && !ctl_reset && !wr_ctl |=>
		$stable(acc) && $stable(dac_code))
		else $error("halted core kept moving");
	chk_release_latency: assert property ($fell(ctl_reset) ##0
		(!ctl_reset && !clock_halt)[*8] |=> hold_count == 4'h0)
		else $error("output not released eight cycles after reset");
	chk_phase_sum: assert property (run |=> phase_sum ==
		$past(acc[FREQ_W-1:ACC_LO] + active_phase))
		else $error("phase offset not added");
	chk_half_write: assert property (freq_hit[0] && !full_word && !half_select |=>
		freq_word[0][HALF_W-1:0] == $past(payload)
		&& freq_word[0][FREQ_W-1:HALF_W] == $past(freq_word[0][FREQ_W-1:HALF_W]))
		else $error("half write touched the wrong half");
	chk_full_pair: assert property (freq_hit[1] && full_word && pend_valid && pend_target |=>
		freq_word[1] == $past({payload, pend_lsb}) && !pend_valid)
		else $error("full word pair not committed");
	chk_phase_load: assert property (phase_hit[1] |=>
		phase_off[1] == $past(payload[PHASE_W-1:0]) && $stable(phase_off[0]))
		else $error("phase load went astray");
	chk_ctl_write: assert property (wr_ctl |=> ctl == $past(payload))
		else $error("control word not stored");
	chk_bit_mode: assert property (bit_output_enable && msb_direct |=>
		waveform_pin == {DAC_W{$past(dac_code[DAC_W-1])}})
		else $error("square pin does not follow the MSB");
	chk_word_frame: assert property (word_valid |-> $past(bit_count) == LAST_BIT)
		else $error("word taken without sixteen bits");
	// Pin level while the DAC is off and while the reset bit holds the core
	chk_pin_powerdown: assert property (dac_powerdown && !bit_output_enable |=>
		waveform_pin == DAC_ZERO)
		else $error("powered-down DAC still shows a code");
	chk_reset_midscale: assert property (ctl_reset[*2] ##1
		(ctl_reset && !bit_output_enable && !dac_powerdown) |=> waveform_pin == DAC_MIDSCALE)
		else $error("pin not at midscale while the reset bit is set");

	cov_full_pair: cover property (freq_hit[0] && full_word && pend_valid);
	cov_bit_mode: cover property (bit_output_enable && !msb_direct && $rose(half_square));
	cov_halt_write: cover property (clock_halt && word_valid);
	cov_release: cover property ($fell(ctl_reset) ##[1:20] hold_count == 4'h0);

endmodule : nco_core
`default_nettype wire

// ---- nco_pkg.sv ----
// Shared constants and types of the waveform generator core.
// Assumes a single 200 MHz clock and a 16-bit serial word as the only way in.
package nco_pkg;

	// ******************************
	// Widths
	// ******************************
	localparam int FREQ_W  = 28;
	localparam int PHASE_W = 12;
	localparam int WORD_W  = 16;
	localparam int HALF_W  = 14;
	localparam int DAC_W   = 10;
	localparam int ACC_LO  = FREQ_W - PHASE_W;

	// ******************************
	// Word address codes (top two bits)
	// ******************************
	localparam logic [1:0] ADDR_CONTROL = 2'h0;
	localparam logic [1:0] ADDR_FREQ_A  = 2'h1;
	localparam logic [1:0] ADDR_FREQ_B  = 2'h2;
	localparam logic [1:0] ADDR_PHASE   = 2'h3;

	// ******************************
	// Control word bit positions, and the phase word target bit
	// ******************************
	localparam int BIT_FULL_WORD  = 13;
	localparam int BIT_HALF_SEL   = 12;
	localparam int BIT_FREQ_SEL   = 11;
	localparam int BIT_PHASE_SEL  = 10;
	localparam int BIT_RESET      = 8;
	localparam int BIT_CLOCK_HALT = 7;
	localparam int BIT_DAC_PD     = 6;
	localparam int BIT_BIT_OUT    = 5;
	localparam int BIT_MSB_DIRECT = 3;
	localparam int BIT_MODE       = 1;
	localparam int BIT_PHASE_TGT  = 13;

	// ******************************
	// Values and counts
	// ******************************
	localparam logic [DAC_W-1:0]  DAC_MIDSCALE  = 10'h200;
	localparam logic [DAC_W-1:0]  DAC_ZERO      = 10'h000;
	localparam logic [3:0]        RESET_LATENCY = 4'h8;
	localparam logic [3:0]        LAST_BIT      = 4'hf;
	localparam logic [HALF_W-1:0] CTL_RESET_VAL = 14'h0000;

	// Serial receiver states
	typedef enum logic [2:0] {
		RX_IDLE  = 3'b001,
		RX_SHIFT = 3'b010,
		RX_DONE  = 3'b100
	} rx_state_t;

endpackage : nco_pkg

// ---- sine_lookup_if.sv ----
// Carrier between the core and its sine lookup memory.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface sine_lookup_if;
	import nco_pkg::*;
	logic [PHASE_W-1:0] phase;
	logic [DAC_W-1:0]   amplitude;
	modport requester (output phase, input amplitude);
	modport lookup (input phase, output amplitude);
endinterface : sine_lookup_if
`default_nettype wire

// ---- sine_lookup_rom.sv ----
// Phase to amplitude table: quarter wave of 32 points, mirrored and signed.
// Assumes the phase input is stable for a cycle; answer one cycle later.
`timescale 1ns/1ps
`default_nettype none
module sine_lookup_rom
	import nco_pkg::*;
(
	input wire logic          clk,
	sine_lookup_if.lookup     port
);

	// ******************************
	// Quarter-wave amplitude table
	// ******************************
	function automatic logic [8:0] quarter(input logic [4:0] idx);
		logic [8:0] v;
		v = 9'h000;
		unique case (idx)
			5'h00: v = 9'h00d;  5'h01: v = 9'h026;  5'h02: v = 9'h03f;  5'h03: v = 9'h057;
			5'h04: v = 9'h070;  5'h05: v = 9'h088;  5'h06: v = 9'h0a0;  5'h07: v = 9'h0b8;
			5'h08: v = 9'h0cf;  5'h09: v = 9'h0e6;  5'h0a: v = 9'h0fc;  5'h0b: v = 9'h111;
			5'h0c: v = 9'h126;  5'h0d: v = 9'h13a;  5'h0e: v = 9'h14e;  5'h0f: v = 9'h160;
			5'h10: v = 9'h172;  5'h11: v = 9'h183;  5'h12: v = 9'h193;  5'h13: v = 9'h1a2;
			5'h14: v = 9'h1b0;  5'h15: v = 9'h1bd;  5'h16: v = 9'h1c8;  5'h17: v = 9'h1d3;
			5'h18: v = 9'h1dd;  5'h19: v = 9'h1e5;  5'h1a: v = 9'h1ec;  5'h1b: v = 9'h1f3;
			5'h1c: v = 9'h1f7;  5'h1d: v = 9'h1fb;  5'h1e: v = 9'h1fe;  5'h1f: v = 9'h1ff;
		endcase
		return v;
	endfunction : quarter

	// Quadrant fold: odd quadrants run backwards, upper half is negative
	wire logic [4:0] index   = port.phase[PHASE_W-2] ? ~port.phase[PHASE_W-3:PHASE_W-7]
	                                                 : port.phase[PHASE_W-3:PHASE_W-7];
	wire logic [8:0] mag     = quarter(index);
	wire logic [9:0] signed_ = port.phase[PHASE_W-1] ? (DAC_MIDSCALE - {1'b0, mag})
	                                                 : (DAC_MIDSCALE + {1'b0, mag});

	// Registered read data
	always_ff @(posedge clk) begin
		port.amplitude <= signed_;
	end

endmodule : sine_lookup_rom
`default_nettype wire

// ---- serial_host.sv ----
// Host side model: serial write master framing 16-bit words, MSB first.
// Assumes the core samples data on serial clock falling edges, clk at 200 MHz.
`timescale 1ns/1ps
`default_nettype none
module serial_host (
	input  wire logic clk,
	output logic      serial_clock,
	output logic      serial_data_in,
	output logic      frame_sync_n
);
	// Clock cycles per serial clock level; the bench may slow the host down
	int half = 4;

	// Idle levels: serial clock stands high, frame released
	initial begin
		serial_clock   = 1'b1;
		serial_data_in = 1'b0;
		frame_sync_n   = 1'b1;
	end

	// Sends the top nbits of a word; fewer than 16 gives a frame that is dropped
	task automatic send_bits(input logic [15:0] word, input int nbits);
		@(posedge clk);
		frame_sync_n <= 1'b0;
		for (int i = 0; i < nbits; i++) begin
			serial_data_in <= word[15-i];
			repeat (half) @(posedge clk);
			serial_clock <= 1'b0;
			repeat (half) @(posedge clk);
			serial_clock <= 1'b1;
		end
		repeat (half) @(posedge clk);
		frame_sync_n   <= 1'b1;
		serial_data_in <= ~serial_data_in;
		repeat (2 * half) @(posedge clk);
	endtask : send_bits
endmodule : serial_host
`default_nettype wire

// ---- nco_waveform_programming_test.sv ----
// Self-checking bench of the waveform core, driven through the serial host model.
// Assumes one 200 MHz clock shared by the core and the host model.
`timescale 1ns/1ps
`default_nettype none
module nco_waveform_programming_test;
	import nco_pkg::*;
	localparam logic [15:0] C_FULL = 16'h2000, C_HSEL = 16'h1000, C_FSEL = 16'h0800;
	localparam logic [15:0] C_PSEL = 16'h0400, C_RST = 16'h0100, C_HALT = 16'h0080;
	localparam logic [15:0] C_PD = 16'h0040, C_BIT = 16'h0020, C_DIR = 16'h0008;
	localparam logic [15:0] C_MODE = 16'h0002;
	logic             clk = 1'b0;
	logic             rstn = 1'b0;
	logic             serial_clock, serial_data_in, frame_sync_n, dac_active;
	logic [DAC_W-1:0] waveform_pin, held;
	logic [27:0]      fa, fb;
	logic [11:0]      p;
	logic [15:0]      cur;
	int               errors = 0;
	int               comparisons = 0;
	int               n;
	realtime          last_fall;

	// ******************************
	// Clock, core and host
	// ******************************
	always #2.5 clk = ~clk;
	always @(negedge serial_clock) last_fall = $realtime;
	nco_core i_dut (.clk(clk), .rstn(rstn), .serial_clock(serial_clock),
		.serial_data_in(serial_data_in), .frame_sync_n(frame_sync_n),
		.waveform_pin(waveform_pin), .dac_active(dac_active));
	serial_host i_host (.clk(clk), .serial_clock(serial_clock),
		.serial_data_in(serial_data_in), .frame_sync_n(frame_sync_n));

	// ******************************
	// Checks, expectations and bus tasks
	// ******************************
	task automatic check(input bit ok, input string what);
		comparisons++;
		if (!ok) begin
			errors++;
			$display("mismatch at %0t: %s", $time, what);
		end
	endtask : check
	task automatic tally_and_finish;
		$display("comparisons %0d, errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : tally_and_finish
	function automatic int sine_code(input logic [11:0] ph);
		return 512 + $rtoi(511.0 * $sin(6.283185307 * ph / 4096.0));
	endfunction : sine_code
	function automatic int tri_code(input logic [11:0] ph);
		return ph[11] ? 1023 - int'(ph[10:1]) : int'(ph[10:1]);
	endfunction : tri_code
	function automatic bit near(input logic [9:0] v, input int e, input int tol);
		return (^v !== 1'bx) && int'(v) >= e - tol && int'(v) <= e + tol;
	endfunction : near
	// One word, then time for synchronisers and pipeline to settle
	task automatic put(input logic [15:0] w);
		i_host.send_bits(w, 16);
		repeat (12) @(posedge clk);
		#1;
	endtask : put
	task automatic set_ctl(input logic [15:0] w);
		cur = w;
		put(w);
	endtask : set_ctl
	task automatic set_freq(input logic [1:0] a, input logic [27:0] f);
		set_ctl(cur | C_FULL);
		put({a, f[13:0]});
		put({a, f[27:14]});
	endtask : set_freq
	// Cycles until the next rise of the output MSB, bounded
	task automatic wait_rise(output int k);
		logic last;
		k = 0;
		do begin
			last = waveform_pin[DAC_W-1];
			@(posedge clk);
			#1;
			k++;
			if (k > 4000) begin
				check(1'b0, "no rising edge on waveform_pin");
				tally_and_finish();
			end
		end while (!(last === 1'b0 && waveform_pin[DAC_W-1] === 1'b1));
	endtask : wait_rise
	task automatic check_period(input logic [27:0] f, input int div);
		int k, e;
		wait_rise(k);
		wait_rise(k);
		e = (268435456 / int'(f)) * div;
		check(k >= e - div && k <= e + div, "square period");
	endtask : check_period

	// ******************************
	// Main sequence
	// ******************************
	initial begin
		void'($urandom(65));
		cur = 16'h0000;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		check(waveform_pin === DAC_MIDSCALE && dac_active === 1'b1, "state after reset");
		set_ctl(C_RST);
		set_ctl(16'h0000);
		$display("test reset done");
		// Slow host for the sleep codes
		i_host.half = 8;
		for (int c = 0; c < 4; c++) begin
			set_ctl(16'(c) << BIT_DAC_PD);
			check(dac_active === ~cur[BIT_DAC_PD], "sleep decode");
			check((waveform_pin === DAC_ZERO) === cur[BIT_DAC_PD], "pin in power-down");
		end
		i_host.half = 4;
		$display("test sleep done");
		// Frequency words are zero, so the output shows the phase offset alone
		for (int i = 0; i < 6; i++) begin
			p = 12'($urandom);
			put({2'b11, i[0], 1'($urandom), p});
			put({2'b11, ~i[0], 1'b0, ~p});
			set_ctl(i[0] ? C_PSEL : 16'h0000);
			check(near(waveform_pin, sine_code(p), 40), "sine amplitude");
			set_ctl(cur | C_MODE);
			check(near(waveform_pin, tri_code(p), 4), "triangle amplitude");
		end
		$display("test phase done");
		i_host.send_bits(C_PD, 10);
		repeat (12) @(posedge clk);
		check(dac_active === 1'b1, "short frame taken");
		$display("test short frame done");
		fa = 28'(268435456 / (40 + $urandom_range(200)));
		fb = 28'(268435456 / (40 + $urandom_range(200)));
		set_freq(ADDR_FREQ_A, fa);
		set_freq(ADDR_FREQ_B, fb);
		set_ctl(C_BIT | C_DIR);
		check_period(fa, 1);
		set_ctl(C_BIT);
		check_period(fa, 2);
		set_ctl(C_BIT | C_DIR | C_FSEL);
		check_period(fb, 1);
		set_ctl(C_BIT | C_DIR | C_HSEL);
		put({ADDR_FREQ_A, 14'h0010});
		set_ctl(C_BIT | C_DIR);
		put({ADDR_FREQ_A, 14'h0000});
		fa = 28'h004_0000;
		check_period(fa, 1);
		$display("test frequency done");
		set_ctl(C_BIT | C_DIR | C_HALT);
		held = waveform_pin;
		set_ctl(C_BIT | C_DIR | C_HALT | C_FSEL);
		check(waveform_pin === held, "output moved while halted");
		set_ctl(C_BIT | C_DIR | C_FSEL);
		check_period(fb, 1);
		$display("test halt done");
		put({2'b11, 2'b00, 12'h400});
		set_ctl(C_RST);
		check(waveform_pin === DAC_MIDSCALE, "not midscale in reset");
		cur = 16'h0000;
		// Watch the pin while the releasing word is still on the link
		fork
			i_host.send_bits(16'h0000, 16);
			begin
				n = 0;
				while (waveform_pin === DAC_MIDSCALE && n < 300) begin
					@(posedge clk);
					#1;
					n++;
				end
			end
		join
		n = $rtoi(($realtime - last_fall) / 5.0);
		check(n >= 13 && n <= 20, "restart delay after reset bit");
		set_ctl(C_BIT | C_DIR);
		check_period(fa, 1);
		$display("test reset bit done");
		tally_and_finish();
	end
endmodule : nco_waveform_programming_test
`default_nettype wire
